// [sim/part_cfg_regs_tb.sv]
// self-checking bench for the partition config register block
`timescale 1ns/10ps
module part_cfg_regs_tb;
    import part_pri_pkg::*;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic req_valid_i = 1'b0;
    reg_req_t req_i = '0;
    logic txn_valid_i = 1'b0;
    logic txn_ns_i = 1'b0;
    logic [15:0] txn_part_id_i = 16'h0;
    logic [31:0] rdata_o;
    logic rvalid_o;
    pri_pair_t pri_o;
    logic pri_valid_o;
    logic capt_secure_o;
    logic capt_nonsecure_o;
    int bad_count = 0;
    int checks = 0;
    int seed = 32'h9664;
    logic [31:0] rd_q[$];
    logic [31:0] pri_q[$];
    logic [1:0] cap_q[$];
    logic [15:0] sel_m[2];
    logic [31:0] pri_m[2][16];

    always #20 clock_i = ~clock_i;

    part_cfg_regs DUT (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .req_valid_i(req_valid_i),
        .req_i(req_i),
        .rdata_o(rdata_o),
        .rvalid_o(rvalid_o),
        .txn_valid_i(txn_valid_i),
        .txn_ns_i(txn_ns_i),
        .txn_part_id_i(txn_part_id_i),
        .pri_o(pri_o),
        .pri_valid_o(pri_valid_o),
        .capt_secure_o(capt_secure_o),
        .capt_nonsecure_o(capt_nonsecure_o)
    );

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    // sampled on the falling edge so registered outputs have settled
    always @(negedge clock_i) begin
        if (rvalid_o === 1'b1) begin
            check(32'(rd_q.size() > 0), 32'h1);
            if (rd_q.size() > 0)
                check(rdata_o, rd_q.pop_front());
        end
        if (pri_valid_o === 1'b1) begin
            check(32'(pri_q.size() > 0), 32'h1);
            if (pri_q.size() > 0)
                check(pri_o, pri_q.pop_front());
        end
        if (capt_secure_o === 1'b1 || capt_nonsecure_o === 1'b1) begin
            check(32'(cap_q.size() > 0), 32'h1);
            if (cap_q.size() > 0)
                check({capt_secure_o, capt_nonsecure_o},
                      cap_q.pop_front());
        end
    end

    initial begin
        repeat (6000) @(posedge clock_i);
        check(32'h1, 32'h0);
        final_report();
    end

    // ------------------------------------------------------------
    // drivers with the reference model
    // ------------------------------------------------------------
    task automatic clear_model();
        sel_m[0] = 16'h0;
        sel_m[1] = 16'h0;
        for (int p = 0; p < 16; p++) begin
            pri_m[0][p] = 32'h0;
            pri_m[1][p] = 32'h0;
        end
    endtask : clear_model

    task automatic op(input logic w, input logic ns, input logic [11:0] a,
                      input logic [31:0] d);
        logic [15:0] s;
        s = sel_m[ns];
        req_valid_i <= 1'b1;
        req_i <= '{w, ns, a, d};
        txn_valid_i <= 1'b0;
        if (w && a == OFF_PART_SEL)
            sel_m[ns] = d[15:0];
        if (w && a == OFF_PRI && s < 16)
            pri_m[ns][s[3:0]] = d & PRI_MASK;
        if (w && a == OFF_CAPT && d[NOW_BIT])
            cap_q.push_back({!ns, ns | d[ALL_BIT]});
        if (!w && a == OFF_PART_SEL)
            rd_q.push_back({16'h0, s});
        else if (!w && a == OFF_PRI)
            rd_q.push_back(s < 16 ? pri_m[ns][s[3:0]] : 32'h0);
        else if (!w)
            rd_q.push_back(32'h0);
        @(posedge clock_i);
    endtask : op

    task automatic look(input logic ns, input logic [15:0] pid);
        logic [31:0] v;
        v = 32'h0;
        if (pid < 16)
            v = pri_m[ns][pid[3:0]];
        if (pid < 16 && !DS_ZERO_LOW)
            v[31:16] = ~v[31:16] & DS_MASK;
        if (pid < 16 && !INT_ZERO_LOW)
            v[15:0] = ~v[15:0] & INT_MASK;
        req_valid_i <= 1'b0;
        txn_valid_i <= 1'b1;
        txn_ns_i <= ns;
        txn_part_id_i <= pid;
        pri_q.push_back(v);
        @(posedge clock_i);
    endtask : look

    task automatic drain(input string name);
        int n;
        n = 0;
        req_valid_i <= 1'b0;
        txn_valid_i <= 1'b0;
        while (rd_q.size() + pri_q.size() + cap_q.size() != 0 && n < 20) begin
            @(posedge clock_i);
            n++;
        end
        @(posedge clock_i);
        check(32'(rd_q.size() + pri_q.size() + cap_q.size()), 32'h0);
        $display("test %s done", name);
        if (n == 20)
            final_report();
    endtask : drain

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        logic [31:0] r;
        clear_model();
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 4; k++)
            op(1'b0, k[0], k[1] ? OFF_PRI : OFF_PART_SEL, 32'h0);
        look(1'b0, 16'h0);
        drain("reset values");

        r = $random(seed);
        op(1'b1, 1'b0, OFF_PART_SEL, {r[31:16], 16'h0005});
        op(1'b1, 1'b1, OFF_PART_SEL, {~r[31:16], 16'h0009});
        op(1'b0, 1'b0, OFF_PART_SEL, 32'h0);
        op(1'b0, 1'b1, OFF_PART_SEL, 32'h0);
        drain("separate selectors");

        for (int p = 0; p < 16; p++) begin
            for (int ns = 0; ns < 2; ns++) begin
                op(1'b1, ns[0], OFF_PART_SEL, 32'(p));
                op(1'b1, ns[0], OFF_PRI, $random(seed));
                op(1'b0, ns[0], OFF_PRI, 32'h0);
            end
        end
        for (int p = 0; p < 32; p++)
            look(p[0], 16'(p >> 1));
        drain("priority per partition");

        op(1'b1, 1'b0, OFF_PART_SEL, 32'h0000_0010);
        op(1'b1, 1'b1, OFF_PART_SEL, 32'h0000_ffff);
        op(1'b1, 1'b0, OFF_PRI, $random(seed));
        op(1'b1, 1'b1, OFF_PRI, $random(seed));
        op(1'b0, 1'b0, OFF_PRI, 32'h0);
        op(1'b0, 1'b1, OFF_PRI, 32'h0);
        look(1'b0, 16'h0010);
        look(1'b1, 16'($random(seed)) | 16'h0010);
        op(1'b1, 1'b1, OFF_PART_SEL, 32'h0000_0003);
        op(1'b0, 1'b1, OFF_PRI, 32'h0);
        look(1'b1, 16'h0003);
        drain("selector out of range");

        for (int c = 0; c < 8; c++) begin
            r = $random(seed);
            op(1'b1, c[2], OFF_CAPT, {r[31:2], c[1:0]});
            op(1'b0, c[2], OFF_CAPT, 32'h0);
        end
        drain("capture events");

        op(1'b1, 1'b0, 12'h104, 32'hffff_ffff);
        op(1'b0, 1'b0, 12'h104, 32'h0);
        op(1'b0, 1'b1, 12'hffc, 32'h0);
        op(1'b0, 1'b0, OFF_PART_SEL, 32'h0);
        drain("unmapped offsets");

        rst_i <= 1'b1;
        @(posedge clock_i);
        rst_i <= 1'b0;
        clear_model();
        op(1'b0, 1'b1, OFF_PART_SEL, 32'h0);
        op(1'b0, 1'b1, OFF_PRI, 32'h0);
        look(1'b1, 16'h0003);
        drain("second reset");
        final_report();
    end
endmodule : part_cfg_regs_tb

// [src/capture_gen.sv]
// capture event pulses for secure and non-secure monitors
`timescale 1ns/10ps
module capture_gen (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic ns_i,
    input wire logic [31:0] wdata_i,
    output logic capt_secure_o,
    output logic capt_nonsecure_o
);
    import part_pri_pkg::*;

    wire now_w = wr_i & wdata_i[NOW_BIT];
    // broadcast only honoured from the secure frame
    wire all_w = ~ns_i & wdata_i[ALL_BIT];
    wire sec_evt_w = now_w & ~ns_i;
    wire ns_evt_w = now_w & (ns_i | all_w);

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            capt_secure_o <= 1'h0;
            capt_nonsecure_o <= 1'h0;
        end else begin
            capt_secure_o <= sec_evt_w;
            capt_nonsecure_o <= ns_evt_w;
        end
    end
endmodule : capture_gen

// [src/part_cfg_regs.sv]
// partition selector, priority config and capture event registers
`timescale 1ns/10ps
module part_cfg_regs (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire part_pri_pkg::reg_req_t req_i,
    output logic [31:0] rdata_o,
    output logic rvalid_o,
    input wire logic txn_valid_i,
    input wire logic txn_ns_i,
    input wire logic [15:0] txn_part_id_i,
    output part_pri_pkg::pri_pair_t pri_o,
    output logic pri_valid_o,
    output logic capt_secure_o,
    output logic capt_nonsecure_o
);
    import part_pri_pkg::*;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire hit_sel_w = (req_i.addr == OFF_PART_SEL);
    wire hit_pri_w = (req_i.addr == OFF_PRI);
    wire hit_capt_w = (req_i.addr == OFF_CAPT);
    wire wr_w = req_valid_i & req_i.write;
    wire rd_w = req_valid_i & ~req_i.write;

    // ------------------------------------------------------------
    // partition selectors
    // ------------------------------------------------------------
    logic [15:0] sel_s_ff;
    logic [15:0] sel_ns_ff;
    wire wr_sel_s_w = wr_w & hit_sel_w & ~req_i.ns;
    wire wr_sel_ns_w = wr_w & hit_sel_w & req_i.ns;
    wire [15:0] nxt_sel_w = req_i.wdata[PART_W-1:0];

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sel_s_ff <= SEL_RESET;
            sel_ns_ff <= SEL_RESET;
        end else begin
            if (wr_sel_s_w) begin
                sel_s_ff <= nxt_sel_w;
            end
            if (wr_sel_ns_w) begin
                sel_ns_ff <= nxt_sel_w;
            end
        end
    end

    // ------------------------------------------------------------
    // priority register access
    // ------------------------------------------------------------
    // the security state of the access picks its own selector, so the
    // two frames can never reach each other's partitions
    wire [15:0] cur_sel_w = req_i.ns ? sel_ns_ff : sel_s_ff;
    // only the lower partitions are backed by storage; the rest read
    // zero and drop writes, which keeps the memory small
    wire sel_in_range_w = (cur_sel_w[PART_W-1:IDX_W] == '0);
    wire [ENTRY_W-1:0] cfg_idx_w =
        {req_i.ns, cur_sel_w[IDX_W-1:0]};
    wire [31:0] pri_wmask_w = req_i.wdata & PRI_MASK;
    wire pri_wr_w = wr_w & hit_pri_w & sel_in_range_w &
        PRI_PART_PRESENT;

    // ------------------------------------------------------------
    // transaction lookup
    // ------------------------------------------------------------
    wire txn_in_range_w = (txn_part_id_i[PART_W-1:IDX_W] == '0);
    wire [ENTRY_W-1:0] txn_idx_w = {txn_ns_i, txn_part_id_i[IDX_W-1:0]};

    logic [31:0] cfg_rdata_w;
    logic [31:0] txn_rdata_w;

    part_mem u_mem (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .wr_en_i(pri_wr_w),
        .wr_idx_i(cfg_idx_w),
        .wr_data_i(pri_wmask_w),
        .rd_a_idx_i(cfg_idx_w),
        .rd_a_data_o(cfg_rdata_w),
        .rd_b_idx_i(txn_idx_w),
        .rd_b_data_o(txn_rdata_w)
    );

    // ------------------------------------------------------------
    // capture event generation
    // ------------------------------------------------------------
    wire capt_wr_w = wr_w & hit_capt_w;

    capture_gen u_capt (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .wr_i(capt_wr_w),
        .ns_i(req_i.ns),
        .wdata_i(req_i.wdata),
        .capt_secure_o(capt_secure_o),
        .capt_nonsecure_o(capt_nonsecure_o)
    );

    // ------------------------------------------------------------
    // read pipeline: stage one picks the source, stage two drives out
    // ------------------------------------------------------------
    rd_src_t nxt_src_w;
    assign nxt_src_w = ~hit_sel_w ? (hit_pri_w & sel_in_range_w ?
        SRC_PRI : SRC_ZERO) : SRC_SEL;

    logic s1_valid_ff;
    rd_src_t s1_src_ff;
    logic [15:0] s1_sel_ff;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s1_valid_ff <= 1'h0;
            s1_src_ff <= SRC_ZERO;
            s1_sel_ff <= SEL_RESET;
        end else begin
            s1_valid_ff <= rd_w;
            s1_src_ff <= nxt_src_w;
            s1_sel_ff <= cur_sel_w;
        end
    end

    // capture register and unmapped offsets fall to zero
    logic [31:0] nxt_rdata_w;
    always_comb begin
        nxt_rdata_w = 32'h0;
        unique case (s1_src_ff)
            SRC_ZERO: nxt_rdata_w = 32'h0;
            SRC_SEL: nxt_rdata_w = {16'h0, s1_sel_ff};
            SRC_PRI: nxt_rdata_w = cfg_rdata_w & PRI_MASK;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rdata_o <= 32'h0;
            rvalid_o <= 1'h0;
        end else begin
            rdata_o <= s1_valid_ff ? nxt_rdata_w : 32'h0;
            rvalid_o <= s1_valid_ff;
        end
    end

    // ------------------------------------------------------------
    // priority applied to transactions
    // ------------------------------------------------------------
    // outputs are normalised so a larger value is always more urgent;
    // downstream logic then never needs to know the stored polarity
    logic txn_v1_ff;
    logic txn_ok1_ff;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            txn_v1_ff <= 1'h0;
            txn_ok1_ff <= 1'h0;
        end else begin
            txn_v1_ff <= txn_valid_i;
            txn_ok1_ff <= txn_in_range_w;
        end
    end

    wire [15:0] ds_raw_w = txn_rdata_w[DS_LSB +: PRI_W] & DS_MASK;
    wire [15:0] int_raw_w = txn_rdata_w[INT_LSB +: PRI_W] & INT_MASK;
    wire [15:0] ds_norm_w =
        DS_ZERO_LOW ? ds_raw_w : (~ds_raw_w & DS_MASK);
    wire [15:0] int_norm_w =
        INT_ZERO_LOW ? int_raw_w : (~int_raw_w & INT_MASK);
    wire txn_ok_w = txn_v1_ff & txn_ok1_ff;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pri_o <= '0;
            pri_valid_o <= 1'h0;
        end else begin
            pri_valid_o <= txn_v1_ff;
            pri_o.ds <= txn_ok_w ? ds_norm_w : 16'h0;
            pri_o.intp <= txn_ok_w ? int_norm_w : 16'h0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    wire rd_capt_w = rd_w & hit_capt_w;
    wire rd_pri_w = rd_w & hit_pri_w;

    property p_sel_write;
        wr_sel_s_w |=> sel_s_ff == $past(req_i.wdata[15:0]);
    endproperty
    a_sel_write: assert property (p_sel_write)
        else $error("secure selector did not take written value");

    property p_sel_isolation;
        wr_sel_ns_w |=> $stable(sel_s_ff);
    endproperty
    a_sel_isolation: assert property (p_sel_isolation)
        else $error("non-secure write changed secure selector");

    property p_read_latency;
        rd_w |-> ##2 rvalid_o;
    endproperty
    a_read_latency: assert property (p_read_latency)
        else $error("read answer not two cycles after request");

    property p_capt_reads_zero;
        rd_capt_w |-> ##2 (rvalid_o && rdata_o == 32'h0);
    endproperty
    a_capt_reads_zero: assert property (p_capt_reads_zero)
        else $error("capture register read was not zero");

    property p_pri_reserved;
        rd_pri_w |-> ##2 ((rdata_o & ~PRI_MASK) == 32'h0);
    endproperty
    a_pri_reserved: assert property (p_pri_reserved)
        else $error("unimplemented priority bits read non-zero");

    property p_now_zero;
        capt_wr_w && !req_i.wdata[NOW_BIT] |=>
            !capt_secure_o && !capt_nonsecure_o;
    endproperty
    a_now_zero: assert property (p_now_zero)
        else $error("capture event without trigger bit");

    property p_ns_no_secure;
        capt_wr_w && req_i.ns |=> !capt_secure_o;
    endproperty
    a_ns_no_secure: assert property (p_ns_no_secure)
        else $error("non-secure frame hit secure monitors");

    property p_broadcast;
        capt_wr_w && !req_i.ns && req_i.wdata[ALL_BIT] &&
            req_i.wdata[NOW_BIT] |=> capt_secure_o && capt_nonsecure_o;
    endproperty
    a_broadcast: assert property (p_broadcast)
        else $error("broadcast did not reach both monitor groups");

    property p_secure_only;
        capt_wr_w && !req_i.ns && !req_i.wdata[ALL_BIT] &&
            req_i.wdata[NOW_BIT] |=> capt_secure_o && !capt_nonsecure_o;
    endproperty
    a_secure_only: assert property (p_secure_only)
        else $error("secure trigger leaked to non-secure monitors");

    sequence s_pri_wr_rd;
        (pri_wr_w && !req_i.ns) ##1
            (rd_pri_w && !req_i.ns && $stable(sel_s_ff));
    endsequence

    property p_pri_roundtrip;
        s_pri_wr_rd |-> ##2 rdata_o == $past(pri_wmask_w, 3);
    endproperty
    a_pri_roundtrip: assert property (p_pri_roundtrip)
        else $error("priority read back differs from written value");

    property p_txn_latency;
        txn_valid_i |-> ##2 pri_valid_o;
    endproperty
    a_txn_latency: assert property (p_txn_latency)
        else $error("priority lookup not two cycles after request");

    property p_sel_ns_write;
        wr_sel_ns_w |=> sel_ns_ff == $past(req_i.wdata[15:0]);
    endproperty
    a_sel_ns_write: assert property (p_sel_ns_write)
        else $error("non-secure selector did not take written value");

    property p_sel_s_isolation;
        wr_sel_s_w |=> $stable(sel_ns_ff);
    endproperty
    a_sel_s_isolation: assert property (p_sel_s_isolation)
        else $error("secure write changed non-secure selector");

    property p_sel_readback;
        rd_w && hit_sel_w && !req_i.ns |->
            ##2 (rdata_o == {16'h0, $past(sel_s_ff, 2)});
    endproperty
    a_sel_readback: assert property (p_sel_readback)
        else $error("secure selector read back wrong value");

    property p_rvalid_source;
        rvalid_o |-> $past(rd_w, 2);
    endproperty
    a_rvalid_source: assert property (p_rvalid_source)
        else $error("read answer without a read request");

    property p_rdata_idle;
        !rvalid_o |-> rdata_o == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside an answer");

    property p_capt_idle;
        !capt_wr_w |=> !capt_secure_o && !capt_nonsecure_o;
    endproperty
    a_capt_idle: assert property (p_capt_idle)
        else $error("capture event without a capture write");

    property p_ns_trigger;
        capt_wr_w && req_i.ns && req_i.wdata[NOW_BIT] |=>
            capt_nonsecure_o && !capt_secure_o;
    endproperty
    a_ns_trigger: assert property (p_ns_trigger)
        else $error("non-secure trigger missed non-secure monitors");

    property p_txn_range;
        txn_valid_i && !txn_in_range_w |->
            ##2 (pri_valid_o && pri_o == '0);
    endproperty
    a_txn_range: assert property (p_txn_range)
        else $error("unbacked partition gave a non-zero priority");

    property p_ds_width;
        pri_valid_o |-> (pri_o.ds & ~DS_MASK) == 16'h0;
    endproperty
    a_ds_width: assert property (p_ds_width)
        else $error("downstream priority beyond implemented width");

    property p_int_width;
        pri_valid_o |-> (pri_o.intp & ~INT_MASK) == 16'h0;
    endproperty
    a_int_width: assert property (p_int_width)
        else $error("internal priority beyond implemented width");

    c_sel_write: cover property (wr_sel_ns_w ##1 rd_w);
    c_broadcast: cover property (capt_secure_o && capt_nonsecure_o);
    c_pri_roundtrip: cover property (s_pri_wr_rd);
    c_txn_lookup: cover property (pri_valid_o && pri_o.intp != 16'h0);
endmodule : part_cfg_regs

// [src/part_mem.sv]
// per-partition priority storage, one write port, two registered read ports
`timescale 1ns/10ps
module part_mem (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic [part_pri_pkg::ENTRY_W-1:0] wr_idx_i,
    input wire logic [31:0] wr_data_i,
    input wire logic [part_pri_pkg::ENTRY_W-1:0] rd_a_idx_i,
    output logic [31:0] rd_a_data_o,
    input wire logic [part_pri_pkg::ENTRY_W-1:0] rd_b_idx_i,
    output logic [31:0] rd_b_data_o
);
    import part_pri_pkg::*;

    logic [31:0] mem_ff [MEM_DEPTH];

    // cleared on reset so an unwritten partition reads a defined zero
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_ff[i] <= 32'h0;
            end
        end else if (wr_en_i) begin
            mem_ff[wr_idx_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rd_a_data_o <= 32'h0;
            rd_b_data_o <= 32'h0;
        end else begin
            rd_a_data_o <= mem_ff[rd_a_idx_i];
            rd_b_data_o <= mem_ff[rd_b_idx_i];
        end
    end
endmodule : part_mem

// [src/part_pri_pkg.sv]
// constants, field layouts and carrier types for the partition config block
package part_pri_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] OFF_PART_SEL = 12'h100;
    localparam logic [11:0] OFF_PRI = 12'h400;
    localparam logic [11:0] OFF_CAPT = 12'h808;

    // ------------------------------------------------------------
    // partition storage
    // ------------------------------------------------------------
    localparam int unsigned PART_W = 16;
    localparam int unsigned IDX_W = 4;
    localparam int unsigned MEM_DEPTH = 32;
    localparam int unsigned ENTRY_W = 5;
    localparam logic [15:0] SEL_RESET = 16'h0000;

    // ------------------------------------------------------------
    // priority fields and identification values
    // ------------------------------------------------------------
    localparam int unsigned PRI_W = 16;
    localparam int unsigned DS_LSB = 16;
    localparam int unsigned INT_LSB = 0;
    localparam logic PRI_PART_PRESENT = 1'h1;
    localparam logic DS_PRESENT = 1'h1;
    localparam logic INT_PRESENT = 1'h1;
    localparam int unsigned DS_WIDTH = 8;
    localparam int unsigned INT_WIDTH = 4;
    localparam logic DS_ZERO_LOW = 1'h1;
    localparam logic INT_ZERO_LOW = 1'h0;
    localparam logic [15:0] DS_MASK =
        (PRI_PART_PRESENT && DS_PRESENT) ? 16'((1 << DS_WIDTH) - 1) : 16'h0;
    localparam logic [15:0] INT_MASK =
        (PRI_PART_PRESENT && INT_PRESENT) ? 16'((1 << INT_WIDTH) - 1) : 16'h0;
    localparam logic [31:0] PRI_MASK = {DS_MASK, INT_MASK};

    // ------------------------------------------------------------
    // capture event register
    // ------------------------------------------------------------
    localparam int unsigned NOW_BIT = 0;
    localparam int unsigned ALL_BIT = 1;
    localparam logic [2:0] CAPT_SELECT = 3'h7;

    typedef enum logic [1:0] {SRC_ZERO, SRC_SEL, SRC_PRI} rd_src_t;

    typedef struct packed {
        logic write;
        logic ns;
        logic [11:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [15:0] ds;
        logic [15:0] intp;
    } pri_pair_t;
endpackage : part_pri_pkg
